// ==== lut_edge_triggered_ram.sv ====
// Two-generator lookup-table RAM cell with synchronous write and
// combinational read. Assumes user logic on the same clock.
`include "lut_ram_map.svh"
`timescale 1ns/1ns
`default_nettype none
module lut_edge_triggered_ram
    import lut_ram_pkg::*;
#(
    parameter logic [15:0] INIT_F = `INIT_F_DEFAULT,
    parameter logic [15:0] INIT_G = `INIT_G_DEFAULT,
    parameter logic [7:0]  INIT_H = `INIT_H_DEFAULT,
    parameter int          DEPTH  = `LUT_DEPTH
) (
    input  wire logic     clock,
    input  wire logic     rstn,
    input  wire ram_req_t req,
    input  wire ram_cfg_t cfg,
    input  wire logic [3:0] dual_read_addr,
    output logic          ram_read_out_f,
    output logic          ram_read_out_g,
    output logic          ram_read_out,
    output logic          dual_read_out,
    output logic          h_out,
    output logic          ff_x_q,
    output logic          ff_y_q
);
    if (DEPTH != 16) begin : g_bad_depth
        $error("Depth must be 16");
    end

    // Function generator contents
    logic [15:0] mem_f_q;
    logic [15:0] mem_g_q;
    logic        wr_f;
    logic        wr_g;
    logic        data_f;
    logic        data_g;
    logic [3:0]  addr_g_eff;
    logic        wr_phase_q;
    logic        wr_phase_n_q;
    logic        active_edge;
    logic        ram_mode;
    // Write-phase bookkeeping
    logic        ff_load;
    logic [1:0]  since_active_q;

    function automatic logic ff_pick(input logic [1:0] src, input logic f,
                                     input logic g, input logic h, input logic c0);
        case (src)
            `FF_SRC_F: ff_pick = f;
            `FF_SRC_G: ff_pick = g;
            `FF_SRC_H: ff_pick = h;
            default:   ff_pick = c0;
        endcase
    endfunction

    // Fifth address bit decode, shared by both write enables
    function automatic logic half_hit(input logic org, input logic bit4, input logic upper);
        half_hit = !org || (bit4 == upper);
    endfunction

    // Single clock models both edges; polarity picks which phase writes
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            wr_phase_q <= 1'b0;
        end else begin
            wr_phase_q <= ~wr_phase_q;
        end
    end
    assign wr_phase_n_q = ~wr_phase_q;
    // One polarity bit shared by both generators
    assign active_edge = cfg.wclk_falling ? wr_phase_q : wr_phase_n_q;
    assign ram_mode = (cfg.mode != comb_logic);

    // Phase after an active edge; a stalled count means the clock stopped there
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            since_active_q <= 2'h0;
        end else if (active_edge) begin
            since_active_q <= 2'h0;
        end else if (since_active_q != 2'h3) begin
            since_active_q <= since_active_q + 2'h1;
        end
    end

    // 32x1 shares the F address and uses control one as fifth bit
    assign addr_g_eff = cfg.org_32x1 ? req.addr_f : req.addr_g;
    assign data_f = req.control_input_zero;
    assign data_g = cfg.org_32x1 ? req.control_input_zero : req.control_input_one;
    // Enable active high only, never inverted
    assign wr_f = ram_mode && active_edge && req.write_en
                  && half_hit(cfg.org_32x1, req.control_input_one, 1'b0);
    assign wr_g = ram_mode && active_edge && req.write_en
                  && half_hit(cfg.org_32x1, req.control_input_one, 1'b1)
                  && (cfg.mode != dual_ram);

    // Write pulse from captured address, data and enable
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            mem_f_q <= INIT_F;
        end else if (wr_f) begin
            mem_f_q[req.addr_f] <= data_f;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            mem_g_q <= INIT_G;
        end else if (cfg.mode == dual_ram && wr_f) begin
            mem_g_q[req.addr_f] <= data_f;
        end else if (wr_g) begin
            mem_g_q[addr_g_eff] <= data_g;
        end
    end

    // Reads follow address, no clock involved
    always_comb begin
        ram_read_out_f = mem_f_q[req.addr_f];
        ram_read_out_g = mem_g_q[addr_g_eff];
        ram_read_out   = cfg.org_32x1 ? (req.control_input_one ? ram_read_out_g
                                                               : ram_read_out_f)
                                      : ram_read_out_f;
        dual_read_out  = mem_g_q[dual_read_addr];
        h_out = INIT_H[{req.control_input_one, ram_read_out_g, ram_read_out_f}];
    end

    // Output register on write edge or the opposite one
    assign ff_load = active_edge ^ cfg.ff_opposite_edge;
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            ff_x_q <= 1'b0;
            ff_y_q <= 1'b0;
        end else if (ff_load) begin
            ff_x_q <= ff_pick(cfg.ff_src_x, ram_read_out_f, ram_read_out_g, h_out,
                              req.control_input_zero);
            ff_y_q <= ff_pick(cfg.ff_src_y, ram_read_out_f, ram_read_out_g, h_out,
                              req.control_input_zero);
        end
    end

    // Multi-step pieces shared by the write and read-back checks
    sequence f_write_hold_s;
        wr_f ##1 $stable(req.addr_f);
    endsequence

    sequence g_write_hold_s;
        wr_g ##1 $stable(addr_g_eff);
    endsequence

    sequence single_write_hold_s;
        (wr_f && !cfg.org_32x1) ##1 ($stable(req.addr_f) && !cfg.org_32x1);
    endsequence

    sequence dual_write_read_s;
        (cfg.mode == dual_ram && wr_f) ##1 (dual_read_addr == $past(req.addr_f));
    endsequence

    sequence phase_step_s;
        active_edge ##1 $stable(cfg.wclk_falling);
    endsequence

    // Write path
    write_lands_a: assert property (@(posedge clock) disable iff (!rstn)
        wr_f |=> mem_f_q[$past(req.addr_f)] == $past(data_f))
        else $error("F write lost");

    g_write_lands_a: assert property (@(posedge clock) disable iff (!rstn)
        wr_g |=> mem_g_q[$past(addr_g_eff)] == $past(data_g))
        else $error("G write lost");

    no_write_a: assert property (@(posedge clock) disable iff (!rstn)
        !req.write_en |=> $stable(mem_f_q))
        else $error("F changed without enable");

    g_no_write_a: assert property (@(posedge clock) disable iff (!rstn)
        !req.write_en |=> $stable(mem_g_q))
        else $error("G changed without enable");

    we_level_a: assert property (@(posedge clock) disable iff (!rstn)
        wr_f || wr_g |-> req.write_en)
        else $error("Write without high enable");

    // Read path
    read_comb_a: assert property (@(posedge clock) disable iff (!rstn)
        ram_read_out_f == mem_f_q[req.addr_f])
        else $error("Read not combinational");

    rd_after_wr_a: assert property (@(posedge clock) disable iff (!rstn)
        f_write_hold_s |-> ram_read_out_f == $past(data_f))
        else $error("Read after write stale");

    g_rd_after_wr_a: assert property (@(posedge clock) disable iff (!rstn)
        g_write_hold_s |-> ram_read_out_g == $past(data_g))
        else $error("G read after write stale");

    out_after_wr_a: assert property (@(posedge clock) disable iff (!rstn)
        single_write_hold_s |-> ram_read_out == $past(data_f))
        else $error("Data out stale after write");

    single_out_a: assert property (@(posedge clock) disable iff (!rstn)
        !cfg.org_32x1 |-> ram_read_out == ram_read_out_f)
        else $error("Data out not from F");

    // Write edge
    edge_gate_a: assert property (@(posedge clock) disable iff (!rstn)
        !active_edge |=> $stable(mem_f_q) && $stable(mem_g_q))
        else $error("Write off active edge");

    shared_pol_a: assert property (@(posedge clock) disable iff (!rstn)
        wr_g |-> active_edge)
        else $error("G uses other polarity");

    phase_alt_a: assert property (@(posedge clock) disable iff (!rstn)
        phase_step_s |-> !active_edge)
        else $error("Write phase did not alternate");

    pol_swap_a: assert property (@(posedge clock) disable iff (!rstn)
        $changed(cfg.wclk_falling) |-> active_edge == $past(active_edge))
        else $error("Polarity swap skipped a phase");

    stall_limit_a: assert property (@(posedge clock) disable iff (!rstn)
        since_active_q <= `WR_PHASE_LIMIT)
        else $error("Write phase stalled");

    // Organisation and mode
    select_32_a: assert property (@(posedge clock) disable iff (!rstn)
        cfg.org_32x1 && req.control_input_one |-> !wr_f)
        else $error("Fifth bit ignored");

    sel32_low_a: assert property (@(posedge clock) disable iff (!rstn)
        cfg.org_32x1 && !req.control_input_one |-> !wr_g)
        else $error("Low half wrote G");

    sel32_hi_read_a: assert property (@(posedge clock) disable iff (!rstn)
        cfg.org_32x1 && req.control_input_one |-> ram_read_out == ram_read_out_g)
        else $error("Upper half not read");

    sel32_lo_read_a: assert property (@(posedge clock) disable iff (!rstn)
        cfg.org_32x1 && !req.control_input_one |-> ram_read_out == ram_read_out_f)
        else $error("Lower half not read");

    addr_shared_a: assert property (@(posedge clock) disable iff (!rstn)
        cfg.org_32x1 |-> addr_g_eff == req.addr_f)
        else $error("Addresses not shared");

    dual_port_a: assert property (@(posedge clock) disable iff (!rstn)
        cfg.mode == dual_ram && wr_f |=>
            mem_g_q[$past(req.addr_f)] == mem_f_q[$past(req.addr_f)])
        else $error("Dual copies diverge");

    dual_no_g_a: assert property (@(posedge clock) disable iff (!rstn)
        cfg.mode == dual_ram |-> !wr_g)
        else $error("Dual mode used G port");

    dual_read_a: assert property (@(posedge clock) disable iff (!rstn)
        dual_write_read_s |-> dual_read_out == $past(data_f))
        else $error("Dual read stale");

    logic_mode_a: assert property (@(posedge clock) disable iff (!rstn)
        cfg.mode == comb_logic |=> $stable(mem_f_q))
        else $error("Logic mode wrote");

    g_logic_mode_a: assert property (@(posedge clock) disable iff (!rstn)
        cfg.mode == comb_logic |=> $stable(mem_g_q))
        else $error("Logic mode wrote G");

    logic_mode_out_a: assert property (@(posedge clock) disable iff (!rstn)
        cfg.mode == comb_logic |-> !wr_f && !wr_g)
        else $error("Logic mode raised a write");

    level_ram_a: assert property (@(posedge clock) disable iff (!rstn)
        cfg.mode == level_ram && req.write_en && active_edge |-> wr_f || wr_g)
        else $error("Level mode dropped a write");

    // Output flip-flops
    ff_x_load_a: assert property (@(posedge clock) disable iff (!rstn)
        ff_load && cfg.ff_src_x == `FF_SRC_CTRL0 |=> ff_x_q == $past(req.control_input_zero))
        else $error("X flop missed control zero");

    ff_y_load_a: assert property (@(posedge clock) disable iff (!rstn)
        ff_load && cfg.ff_src_y == `FF_SRC_F |=> ff_y_q == $past(ram_read_out_f))
        else $error("Y flop missed F output");

    ff_hold_a: assert property (@(posedge clock) disable iff (!rstn)
        !ff_load |=> $stable(ff_x_q) && $stable(ff_y_q))
        else $error("Output flop moved off its edge");
endmodule
`default_nettype wire

// ==== lut_ram_map.svh ====
// Constants for the lookup-table RAM cell.
// Assumes inclusion by the cell package and module only.
`ifndef LUT_RAM_MAP_SVH
`define LUT_RAM_MAP_SVH
`define LUT_DEPTH        16
`define LUT_ADDR_W       4
`define MODE_LEVEL_RAM   2'h0
`define MODE_EDGE_RAM    2'h1
`define MODE_DUAL_RAM    2'h2
`define MODE_LOGIC       2'h3
`define FF_SRC_F         2'h0
`define FF_SRC_G         2'h1
`define FF_SRC_H         2'h2
`define FF_SRC_CTRL0     2'h3
`define INIT_F_DEFAULT   16'h0000
`define INIT_G_DEFAULT   16'h0000
`define INIT_H_DEFAULT   8'hE8
`define WR_PHASE_LIMIT   2'h2
`endif

// ==== lut_ram_pkg.sv ====
// Types for the lookup-table RAM cell.
// Assumes the constant header is on the include path.
`include "lut_ram_map.svh"
package lut_ram_pkg;
    typedef enum logic [1:0] {
        level_ram  = 2'b00,
        edge_ram   = 2'b01,
        dual_ram   = 2'b10,
        comb_logic = 2'b11
    } fg_mode_t;

    typedef struct packed {
        logic       write_en;
        logic [3:0] addr_f;
        logic [3:0] addr_g;
        logic       control_input_zero;
        logic       control_input_one;
    } ram_req_t;

    typedef struct packed {
        logic       wclk_falling;
        logic       org_32x1;
        fg_mode_t   mode;
        logic [1:0] ff_src_x;
        logic [1:0] ff_src_y;
        logic       ff_opposite_edge;
    } ram_cfg_t;
endpackage

// ==== ram_user_model.sv ====
// User logic model that drives the RAM cell request inputs.
// Assumes a free-running clock; changes its outputs 1 ns after rising edges.
`timescale 1ns/1ns
`default_nettype none
module ram_user_model
    import lut_ram_pkg::*;
(
    input  wire logic     clock,
    output var  ram_req_t req
);
    initial req = '0;
    task automatic drive(input logic we, input logic [3:0] af, input logic [3:0] ag,
                         input logic c0, input logic c1);
        @(posedge clock);
        #1 req = '{we, af, ag, c0, c1};
        if (we) begin
            // Two edges so one active edge falls inside, whatever the polarity
            repeat (2) @(posedge clock);
            #1 req.write_en = 1'b0;
            req.control_input_zero = ~c0;
        end
    endtask
endmodule
`default_nettype wire

// ==== lut_edge_triggered_ram_bench.sv ====
// Self-checking bench for the lookup-table RAM cell.
// Assumes the package, header and user logic model are compiled first.
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin error_cnt++; \
    $display("Error %s expected %h seen %h", nm, e, g); end end
module lut_edge_triggered_ram_bench
    import lut_ram_pkg::*;
;
    localparam logic [15:0] IF = 16'hA5C3;
    localparam logic [15:0] IG = 16'h3C96;
    localparam logic [7:0]  IH = 8'h96;
    logic        clock = 1'b0;
    logic        rstn = 1'b0;
    ram_cfg_t    cfg = '{1'b0, 1'b0, edge_ram, 2'h3, 2'h0, 1'b0};
    logic [3:0]  dra = 4'h0;
    ram_req_t    req;
    logic        rf, rg, ro, dro, ho, fx, fy;
    logic [15:0] mf = IF;
    logic [15:0] mg = IG;
    int          error_cnt = 0;
    int          tests_run = 0;
    always #2 clock = ~clock;
    ram_user_model ram_user_model_i (.clock(clock), .req(req));
    lut_edge_triggered_ram #(.INIT_F(IF), .INIT_G(IG), .INIT_H(IH)) lut_edge_triggered_ram_i (
        .clock(clock), .rstn(rstn), .req(req), .cfg(cfg), .dual_read_addr(dra),
        .ram_read_out_f(rf), .ram_read_out_g(rg), .ram_read_out(ro),
        .dual_read_out(dro), .h_out(ho), .ff_x_q(fx), .ff_y_q(fy));
    task automatic check_all(input string nm, input logic c1);
        for (int a = 0; a < 16; a++) begin
            ram_user_model_i.drive(1'b0, 4'(a), 4'(15 - a), 1'b0, c1);
            #1;
            `CHK("read_f", mf[a], rf)
            `CHK("read_g", mg[15 - a], rg)
            `CHK("h_out", IH[{c1, mg[15 - a], mf[a]}], ho)
        end
        $display("test %s done", nm);
    endtask
    task automatic wr(input logic [3:0] af, input logic [3:0] ag, input logic c0, input logic c1);
        ram_user_model_i.drive(1'b1, af, ag, c0, c1);
        // Expectation follows the organisation, logic mode keeps contents
        if (cfg.mode == comb_logic)
            return;
        if (cfg.org_32x1) begin
            if (c1)
                mg[af] = c0;
            else
                mf[af] = c0;
        end else if (cfg.mode == dual_ram) begin
            mf[af] = c0;
            mg[af] = c0;
        end else begin
            mf[af] = c0;
            mg[ag] = c1;
        end
    endtask
    task automatic t_write();
        wr(4'h5, 4'h9, ~mf[5], ~mg[9]);
        cfg.wclk_falling = 1'b1;
        wr(4'h0, 4'hF, ~mf[0], ~mg[15]);
        ram_user_model_i.drive(1'b0, 4'h1, 4'h2, ~mf[1], ~mg[2]);
        repeat (3) @(posedge clock);
        check_all("write", 1'b1);
    endtask
    task automatic t_32x1();
        cfg.org_32x1 = 1'b1;
        wr(4'h7, 4'h7, ~mg[7], 1'b1);
        wr(4'hC, 4'hC, ~mf[12], 1'b0);
        for (int i = 0; i < 2; i++) begin
            ram_user_model_i.drive(1'b0, 4'h7, 4'h7, 1'b0, i[0]);
            #1;
            `CHK("read_32", i[0] ? mg[7] : mf[7], ro)
        end
        cfg.org_32x1 = 1'b0;
        check_all("org32", 1'b0);
    endtask
    task automatic t_modes();
        cfg.mode = comb_logic;
        wr(4'h3, 4'h3, ~mf[3], ~mg[3]);
        check_all("logic", 1'b0);
        cfg.mode = dual_ram;
        dra = 4'h2;
        wr(4'h2, 4'h2, ~mg[2], 1'b0);
        `CHK("dual_out", mg[2], dro)
        cfg.mode = level_ram;
        wr(4'h4, 4'h6, ~mf[4], ~mg[6]);
        check_all("level", 1'b0);
        cfg.mode = edge_ram;
        ram_user_model_i.drive(1'b0, 4'h0, 4'h0, 1'b1, 1'b0);
        repeat (3) @(posedge clock);
        #1;
        `CHK("ff_x", 1'b1, fx)
        `CHK("ff_y", mf[0], fy)
        cfg.ff_opposite_edge = 1'b1;
        ram_user_model_i.drive(1'b0, 4'h1, 4'h0, 1'b0, 1'b0);
        repeat (3) @(posedge clock);
        #1;
        `CHK("ff_x_opp", 1'b0, fx)
        `CHK("ff_y_opp", mf[1], fy)
        $display("test modes done");
    endtask
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        #8000;
        error_cnt++;
        end_of_test();
    end
    initial begin
        repeat (12) @(posedge clock);
        #1 rstn = 1'b1;
        check_all("preload", 1'b0);
        t_write();
        t_32x1();
        t_modes();
        end_of_test();
    end
endmodule
`default_nettype wire
